//--- logic/pewi_top.sv
// Function
// R01 - enabled selected edge exits halt or idle
// R02 - eight bit rw wake enable mask
// R03 - edge bit one falling, zero rising
// R04 - selected edge sets and holds pending
// R05 - software clears pending by writing register
// R06 - halt request ignored while enabled pending
// R07 - reset clears enable, edge, pending registers
// R08 - eight edge sources share one request
// R09 - request needs port, cpu enables, active pin
// R10 - irq disabled wake resumes next instruction
// R11 - irq enabled wake runs service routine
// R12 - edge change order: disable, edge, clear, enable
// R13 - after reset set edges, clear pending first
// R14 - halt wake waits 256 cycles before clocks
// R15 - detection works while core clock stopped
`timescale 1ns/1ps
module pewi_top (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  port_pins,
   input  wire logic        cpu_global_irq_enable,
   input  wire logic        halt_req,
   input  wire logic        idle_req,
   output logic             core_clk_en,
   output logic             osc_en,
   output logic             wake_resume,
   output logic             port_irq_req,
   output logic             irq
);
   // ----------------------------------------
   // pin synchroniser and edge detect
   // ----------------------------------------
   // the detector sits on the always-on clock, so a stopped core clock
   // cannot lose an edge; pulses shorter than one clk period can be missed
   logic [7:0] pin_s1_reg;
   logic [7:0] pin_s2_reg;
   logic [7:0] pin_s3_reg;
   always_ff @(posedge clk) begin
      pin_s1_reg <= port_pins;                  // see R15
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
   end

   logic [7:0] wake_pin_enable_mask_reg;
   logic [7:0] wake_edge_polarity_reg;
   logic [7:0] wake_pending_flags_reg;
   logic [7:0] wake_pending_flags_next;
   logic       port_irq_global_enable_reg;

   wire [7:0] pin_rise = pin_s2_reg & ~pin_s3_reg;
   wire [7:0] pin_fall = ~pin_s2_reg & pin_s3_reg;
   wire [7:0] pin_hit  = (wake_edge_polarity_reg & pin_fall) |
                         (~wake_edge_polarity_reg & pin_rise);   // see R03
   wire       wake_any = |(wake_pin_enable_mask_reg & wake_pending_flags_reg);

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   logic             pready_reg;
   logic      [31:0] prdata_reg;
   logic             pslverr_reg;
   logic [pewi_pkg::EVT_W-1:0] evt_stat_reg;
   logic [pewi_pkg::EVT_W-1:0] evt_en_reg;
   pewi_pkg::pewi_mode_e       mode_reg;
   pewi_pkg::pewi_mode_e       mode_next;

   wire acc      = psel & penable;
   wire fire     = acc & pready_reg;
   wire wr_fire  = fire & pwrite;
   wire sel_en   = (paddr == pewi_pkg::OFS_ENABLE);
   wire sel_edg  = (paddr == pewi_pkg::OFS_EDGE);
   wire sel_pnd  = (paddr == pewi_pkg::OFS_PENDING);
   wire sel_ctl  = (paddr == pewi_pkg::OFS_CONTROL);
   wire sel_mode = (paddr == pewi_pkg::OFS_MODE);
   wire sel_ist  = (paddr == pewi_pkg::OFS_IRQ_STAT);
   wire sel_icl  = (paddr == pewi_pkg::OFS_IRQ_CLR);
   wire sel_ien  = (paddr == pewi_pkg::OFS_IRQ_EN);
   wire mapped   = sel_en | sel_edg | sel_pnd | sel_ctl | sel_mode |
                   sel_ist | sel_icl | sel_ien;
   wire [31:0] rd_mux =
      sel_en   ? {24'h00_0000, wake_pin_enable_mask_reg} :
      sel_edg  ? {24'h00_0000, wake_edge_polarity_reg} :
      sel_pnd  ? {24'h00_0000, wake_pending_flags_reg} :
      sel_ctl  ? {31'h0000_0000, port_irq_global_enable_reg} :
      sel_mode ? {30'h0000_0000, mode_reg} :
      sel_ist  ? {30'h0000_0000, evt_stat_reg} :
      sel_ien  ? {30'h0000_0000, evt_en_reg} : 32'h0000_0000;

   // one wait state: pready rises in the second access cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg  <= acc & ~pready_reg;
         prdata_reg  <= (acc & ~pready_reg & ~pwrite) ? rd_mux : 32'h0000_0000;
         pslverr_reg <= acc & ~pready_reg & ~mapped;
      end
   end
   assign pready  = pready_reg;
   assign prdata  = prdata_reg;
   assign pslverr = pslverr_reg;

   // ----------------------------------------
   // wake registers
   // ----------------------------------------
   // a hit in the same cycle as a software clear stays set
   always_comb begin
      wake_pending_flags_next = wake_pending_flags_reg;
      if (wr_fire && sel_pnd)
         wake_pending_flags_next = pwdata[7:0];   // see R05
      wake_pending_flags_next = wake_pending_flags_next | pin_hit;   // see R04
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wake_pin_enable_mask_reg   <= pewi_pkg::RST_PINREG;   // see R07
         wake_edge_polarity_reg     <= pewi_pkg::RST_PINREG;   // see R07
         wake_pending_flags_reg     <= pewi_pkg::RST_PINREG;   // see R07
         port_irq_global_enable_reg <= 1'b0;
      end else begin
         if (wr_fire && sel_en)
            wake_pin_enable_mask_reg <= pwdata[7:0];   // see R02
         if (wr_fire && sel_edg)
            wake_edge_polarity_reg <= pwdata[7:0];     // see R03
         if (wr_fire && sel_ctl)
            port_irq_global_enable_reg <= pwdata[pewi_pkg::CTL_PORT_IE];
         wake_pending_flags_reg <= wake_pending_flags_next;
      end
   end

   // ----------------------------------------
   // power mode sequencer
   // ----------------------------------------
   logic [8:0] osc_cnt_reg;
   logic [8:0] osc_cnt_next;
   wire halt_refused = (mode_reg == pewi_pkg::PEWI_RUN) & halt_req & wake_any;

   always_comb begin
      mode_next    = mode_reg;
      osc_cnt_next = osc_cnt_reg;
      unique case (mode_reg)
         pewi_pkg::PEWI_RUN: begin
            if (halt_req && !wake_any)           // see R06
               mode_next = pewi_pkg::PEWI_HALTED;
            else if (idle_req && !halt_req)
               mode_next = pewi_pkg::PEWI_IDLED;
         end
         pewi_pkg::PEWI_HALTED: begin
            if (wake_any) begin                  // see R01
               mode_next    = pewi_pkg::PEWI_OSC_WAIT;
               osc_cnt_next = pewi_pkg::OSC_WAKE_CYC - 9'h001;   // see R14
            end
         end
         pewi_pkg::PEWI_IDLED: begin
            if (wake_any)                        // see R01
               mode_next = pewi_pkg::PEWI_RUN;
         end
         pewi_pkg::PEWI_OSC_WAIT: begin
            if (osc_cnt_reg == 9'h000)
               mode_next = pewi_pkg::PEWI_RUN;   // see R14
            else
               osc_cnt_next = osc_cnt_reg - 9'h001;
         end
      endcase
   end

   // the core resumes on its own; with port_irq_req high it vectors first
   wire resume = (mode_reg != pewi_pkg::PEWI_RUN) &
                 (mode_next == pewi_pkg::PEWI_RUN);
   logic core_clk_en_reg;
   logic osc_en_reg;
   logic wake_resume_reg;
   logic port_irq_req_reg;
   logic irq_reg;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode_reg         <= pewi_pkg::PEWI_RUN;
         osc_cnt_reg      <= 9'h000;
         core_clk_en_reg  <= 1'b1;
         osc_en_reg       <= 1'b1;
         wake_resume_reg  <= 1'b0;
         port_irq_req_reg <= 1'b0;
      end else begin
         mode_reg         <= mode_next;
         osc_cnt_reg      <= osc_cnt_next;
         core_clk_en_reg  <= (mode_next == pewi_pkg::PEWI_RUN);
         osc_en_reg       <= (mode_next != pewi_pkg::PEWI_HALTED);
         wake_resume_reg  <= resume;                       // see R10
         port_irq_req_reg <= port_irq_global_enable_reg &
                             cpu_global_irq_enable & wake_any;   // see R09 R08 R11
      end
   end
   assign core_clk_en  = core_clk_en_reg;
   assign osc_en       = osc_en_reg;
   assign wake_resume  = wake_resume_reg;
   assign port_irq_req = port_irq_req_reg;

   // ----------------------------------------
   // event status and interrupt
   // ----------------------------------------
   wire [pewi_pkg::EVT_W-1:0] evt_set = {halt_refused, resume};
   wire [pewi_pkg::EVT_W-1:0] evt_clr =
      (wr_fire && sel_icl) ? pwdata[pewi_pkg::EVT_W-1:0] : 2'h0;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         evt_stat_reg <= pewi_pkg::RST_EVT;
         evt_en_reg   <= pewi_pkg::RST_EVT;
         irq_reg      <= 1'b0;
      end else begin
         evt_stat_reg <= (evt_stat_reg & ~evt_clr) | evt_set;
         if (wr_fire && sel_ien)
            evt_en_reg <= pwdata[pewi_pkg::EVT_W-1:0];
         irq_reg <= |(((evt_stat_reg & ~evt_clr) | evt_set) &
                    ((wr_fire && sel_ien) ? pwdata[pewi_pkg::EVT_W-1:0] : evt_en_reg));
      end
   end
   assign irq = irq_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_pend_sets: assert property (@(posedge clk) disable iff (sys_rst)   // see R04
      (pin_hit != 8'h00) |=> ((wake_pending_flags_reg & $past(pin_hit)) == $past(pin_hit)))
      else $error("pending bit not set by edge");
   a_pend_holds: assert property (@(posedge clk) disable iff (sys_rst)   // see R05
      !(wr_fire && sel_pnd) |=> ((wake_pending_flags_reg & $past(wake_pending_flags_reg))
                                 == $past(wake_pending_flags_reg)))
      else $error("pending bit lost without write");
   a_halt_block: assert property (@(posedge clk) disable iff (sys_rst)   // see R06
      (mode_reg == pewi_pkg::PEWI_RUN && halt_req && wake_any)
      |=> mode_reg != pewi_pkg::PEWI_HALTED)
      else $error("halt entered while wake pending");
   a_halt_wake: assert property (@(posedge clk) disable iff (sys_rst)   // see R01
      (mode_reg == pewi_pkg::PEWI_HALTED && wake_any)
      |=> mode_reg == pewi_pkg::PEWI_OSC_WAIT ##0 !core_clk_en ##0 osc_en)
      else $error("halt not left on wake");
   a_osc_wait: assert property (@(posedge clk) disable iff (sys_rst)   // see R14
      $rose(mode_reg == pewi_pkg::PEWI_OSC_WAIT) |-> ##255
      (mode_reg == pewi_pkg::PEWI_OSC_WAIT && osc_cnt_reg == 9'h000) ##1
      (mode_reg == pewi_pkg::PEWI_RUN && core_clk_en))
      else $error("oscillator wait not 256 cycles");
   a_idle_wake: assert property (@(posedge clk) disable iff (sys_rst)   // see R01
      (mode_reg == pewi_pkg::PEWI_IDLED && wake_any) |=> wake_resume && core_clk_en)
      else $error("idle not left on wake");
   a_port_irq: assert property (@(posedge clk) disable iff (sys_rst)   // see R09
      port_irq_req == $past(port_irq_global_enable_reg && cpu_global_irq_enable && wake_any))
      else $error("port request mismatch");
   a_reset_clr: assert property (@(posedge clk)   // see R07
      sys_rst |=> (wake_pin_enable_mask_reg == 8'h00 &&
                          wake_edge_polarity_reg == 8'h00 &&
                          wake_pending_flags_reg == 8'h00))
      else $error("wake registers not cleared by reset");
   a_mask_write: assert property (@(posedge clk) disable iff (sys_rst)   // see R02
      (wr_fire && sel_en) |=> wake_pin_enable_mask_reg == $past(pwdata[7:0]))
      else $error("enable mask write lost");
   // register effects land at the accepting edge and are sampled one edge later, hence the next-cycle form
   a_edge_write: assert property (@(posedge clk) disable iff (sys_rst)   // see R03
      (wr_fire && sel_edg) |=> wake_edge_polarity_reg == $past(pwdata[7:0]))
      else $error("edge polarity write lost");
   a_pend_write: assert property (@(posedge clk) disable iff (sys_rst)   // see R05
      (wr_fire && sel_pnd) |=>
      wake_pending_flags_reg == ($past(pwdata[7:0]) | $past(pin_hit)))
      else $error("pending write or same-cycle edge lost");
   a_pend_quiet: assert property (@(posedge clk) disable iff (sys_rst)   // see R04
      (!(wr_fire && sel_pnd) && pin_hit == 8'h00) |=> $stable(wake_pending_flags_reg))
      else $error("pending changed without edge or write");
   a_halt_enter: assert property (@(posedge clk) disable iff (sys_rst)   // see R06
      (mode_reg == pewi_pkg::PEWI_RUN && halt_req && !wake_any)
      |=> mode_reg == pewi_pkg::PEWI_HALTED && !core_clk_en && !osc_en)
      else $error("halt not entered");
   a_idle_enter: assert property (@(posedge clk) disable iff (sys_rst)   // see R01
      (mode_reg == pewi_pkg::PEWI_RUN && idle_req && !halt_req)
      |=> mode_reg == pewi_pkg::PEWI_IDLED && !core_clk_en && osc_en)
      else $error("idle not entered");
   a_idle_stay: assert property (@(posedge clk) disable iff (sys_rst)   // see R01
      (mode_reg == pewi_pkg::PEWI_IDLED && !wake_any) |=> mode_reg == pewi_pkg::PEWI_IDLED)
      else $error("idle left without wake");
   a_refuse_evt: assert property (@(posedge clk) disable iff (sys_rst)   // see R06
      halt_refused |=> evt_stat_reg[pewi_pkg::EVT_REFUSE])
      else $error("refused halt not flagged");
   a_wake_evt: assert property (@(posedge clk) disable iff (sys_rst)   // see R10
      wake_resume |-> evt_stat_reg[pewi_pkg::EVT_WAKE])
      else $error("wake resume not flagged");
   a_halt_clocks: assert property (@(posedge clk) disable iff (sys_rst)   // see R14
      mode_reg == pewi_pkg::PEWI_HALTED |-> !core_clk_en && !osc_en)
      else $error("clocks running while halted");
   a_ctl_write: assert property (@(posedge clk) disable iff (sys_rst)   // see R09
      (wr_fire && sel_ctl) |=>
      port_irq_global_enable_reg == $past(pwdata[pewi_pkg::CTL_PORT_IE]))
      else $error("port enable write lost");
endmodule

//--- logic/pewi_pkg.sv
package pewi_pkg;
   // ----------------------------------------
   // register map, byte addresses
   // ----------------------------------------
   localparam logic [7:0] OFS_ENABLE   = 8'h00;
   localparam logic [7:0] OFS_EDGE     = 8'h04;
   localparam logic [7:0] OFS_PENDING  = 8'h08;
   localparam logic [7:0] OFS_CONTROL  = 8'h0c;
   localparam logic [7:0] OFS_MODE     = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_CLR  = 8'h18;
   localparam logic [7:0] OFS_IRQ_EN   = 8'h1c;
   // ----------------------------------------
   // fields and reset values
   // ----------------------------------------
   localparam int          PINS          = 8;
   localparam int          CTL_PORT_IE   = 0;
   localparam int          EVT_WAKE      = 0;
   localparam int          EVT_REFUSE    = 1;
   localparam int          EVT_W         = 2;
   localparam logic [7:0]  RST_PINREG    = 8'h00;
   localparam logic [1:0]  RST_EVT       = 2'h0;
   // ----------------------------------------
   // timing: oscillator wait length after halt wake
   // ----------------------------------------
   localparam logic [8:0]  OSC_WAKE_CYC  = 9'h100;
   typedef enum logic [1:0] {
      PEWI_RUN,
      PEWI_HALTED,
      PEWI_IDLED,
      PEWI_OSC_WAIT
   } pewi_mode_e;
endpackage

//--- tb/pewi_pin_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// port pin sources
// ----------------------------------------
module pewi_pin_model (
   input  wire logic       clk,
   input  wire logic [7:0] level_cmd,
   output logic      [7:0] port_pins
);
   // driven levels only: floating pins after reset would fake edges
   always_ff @(posedge clk) begin
      port_pins <= level_cmd;
   end
endmodule

//--- tb/test_pin_edge_wakeup_interrupt.sv
`timescale 1ns/1ps
module test_pin_edge_wakeup_interrupt;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  pins_cmd = 8'h02;
   logic [7:0]  port_pins;
   logic        cpu_en = 1'b0;
   logic        halt_req = 1'b0;
   logic        idle_req = 1'b0;
   logic        core_clk_en;
   logic        osc_en;
   logic        wake_resume;
   logic        port_irq_req;
   logic        irq;
   logic [31:0] q;
   logic        slverr;
   int          failures = 0;
   int          samples_checked = 0;
   int          c;
   always #5 clk = ~clk;
   pewi_pin_model PINS (.clk(clk), .level_cmd(pins_cmd), .port_pins(port_pins));
   pewi_top DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port_pins(port_pins), .cpu_global_irq_enable(cpu_en), .halt_req(halt_req),
      .idle_req(idle_req), .core_clk_en(core_clk_en), .osc_en(osc_en),
      .wake_resume(wake_resume), .port_irq_req(port_irq_req), .irq(irq));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
         failures++;
      end
   endtask
   // apb cycle; waits for pready instead of assuming the wait state count
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         failures++;
         report_and_stop();
      end
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, q, exp);
   endtask
   task automatic pulse(input logic h);
      @(posedge clk);
      halt_req <= h;
      idle_req <= !h;
      @(posedge clk);
      halt_req <= 1'b0;
      idle_req <= 1'b0;
      repeat (3) @(negedge clk);
   endtask
   task automatic wait_wake();
      c = 0;
      do begin
         @(negedge clk);
         c++;
      end while (wake_resume !== 1'b1 && c < 600);
      if (c >= 600) begin
         failures++;
         report_and_stop();
      end
   endtask
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 5; i++) rdc("reset", 8'(4 * i), 32'h0000_0000);
      apb(1'b1, pewi_pkg::OFS_EDGE, 32'h0000_0002);
      rdc("edge", pewi_pkg::OFS_EDGE, 32'h0000_0002);
      apb(1'b1, pewi_pkg::OFS_PENDING, 32'h0000_0000);
      apb(1'b1, pewi_pkg::OFS_ENABLE, 32'hffff_ff5a);
      rdc("enable", pewi_pkg::OFS_ENABLE, 32'h0000_005a);
      rdc("unmapped", 8'h20, 32'h0000_0000);
      chk("slverr", 32'(slverr), 32'h0000_0001);
      apb(1'b1, pewi_pkg::OFS_ENABLE, 32'h0000_0000);
      apb(1'b1, pewi_pkg::OFS_PENDING, 32'h0000_0000);
      pins_cmd <= 8'h01;
      repeat (6) @(posedge clk);
      rdc("edge_hit", pewi_pkg::OFS_PENDING, 32'h0000_0003);
      pins_cmd <= 8'h02;
      repeat (6) @(posedge clk);
      rdc("hold", pewi_pkg::OFS_PENDING, 32'h0000_0003);
      apb(1'b1, pewi_pkg::OFS_ENABLE, 32'h0000_0001);
      apb(1'b1, pewi_pkg::OFS_CONTROL, 32'h0000_0001);
      repeat (3) @(negedge clk);
      chk("irq_no_cpu", 32'(port_irq_req), 32'h0000_0000);
      @(posedge clk);
      cpu_en <= 1'b1;
      repeat (3) @(negedge clk);
      chk("irq_on", 32'(port_irq_req), 32'h0000_0001);
      apb(1'b1, pewi_pkg::OFS_CONTROL, 32'h0000_0000);
      repeat (2) @(negedge clk);
      chk("irq_no_port", 32'(port_irq_req), 32'h0000_0000);
      apb(1'b1, pewi_pkg::OFS_IRQ_EN, 32'h0000_0003);
      pulse(1'b1);
      rdc("refused", pewi_pkg::OFS_MODE, 32'h0000_0000);
      rdc("refuse_evt", pewi_pkg::OFS_IRQ_STAT, 32'h0000_0002);
      chk("evt_irq", 32'(irq), 32'h0000_0001);
      apb(1'b1, pewi_pkg::OFS_IRQ_CLR, 32'h0000_0002);
      rdc("evt_clr", pewi_pkg::OFS_IRQ_STAT, 32'h0000_0000);
      chk("evt_irq_off", 32'(irq), 32'h0000_0000);
      // edge change for pin 2 in the safe order
      apb(1'b1, pewi_pkg::OFS_ENABLE, 32'h0000_0000);
      apb(1'b1, pewi_pkg::OFS_EDGE, 32'h0000_0000);
      apb(1'b1, pewi_pkg::OFS_PENDING, 32'h0000_0000);
      rdc("sw_clear", pewi_pkg::OFS_PENDING, 32'h0000_0000);
      apb(1'b1, pewi_pkg::OFS_ENABLE, 32'h0000_0004);
      pulse(1'b1);
      chk("halt_clk", {core_clk_en, osc_en}, 32'h0000_0000);
      rdc("halted", pewi_pkg::OFS_MODE, 32'h0000_0001);
      pins_cmd <= 8'h06;
      wait_wake();
      chk("osc_wait", 32'(c >= 257 && c <= 268), 32'h0000_0001);
      chk("resume_clk", 32'(core_clk_en), 32'h0000_0001);
      rdc("wake_evt", pewi_pkg::OFS_IRQ_STAT, 32'h0000_0001);
      apb(1'b1, pewi_pkg::OFS_PENDING, 32'h0000_0000);
      apb(1'b1, pewi_pkg::OFS_EDGE, 32'h0000_0004);
      pulse(1'b0);
      rdc("idled", pewi_pkg::OFS_MODE, 32'h0000_0002);
      pins_cmd <= 8'h02;
      wait_wake();
      chk("idle_wake", 32'(c <= 10), 32'h0000_0001);
      rdc("run", pewi_pkg::OFS_MODE, 32'h0000_0000);
      report_and_stop();
   end
endmodule
